// File: iosd_cfg.svh
// Purpose: constants for the sampling and diagnostics block
// Assumes: 200 MHz clock
// Notes: parameter indices are the command port's own codes
`ifndef IOSD_CFG_SVH
`define IOSD_CFG_SVH
`define PAR_SAMPLE_PERIOD   4'h0
`define PAR_CHANGE_MASK     4'h1
`define PAR_SUPPLY_THRESH   4'h2
`define PAR_DEST_HIGH       4'h3
`define PAR_DEST_LOW        4'h4
`define PAR_SERIAL_RATE     4'h5
`define PAR_FW_VERSION      4'h6
`define PAR_HW_VERSION      4'h7
`define PAR_JOIN_STATUS     4'h8
`define PAR_SUPPLY_MV       4'h9
`define PAR_LAST_HOP        4'hA
`define PAR_TEMPERATURE     4'hB
`define PERIOD_MIN          16'h0032
`define JOIN_INIT           8'hFF
`define JOIN_OK             8'h00
`define SUPPLY_MASK_BIT     7
`define MS_NS               1000000
`define CLK_NS              5
`define CYC_PER_MS          (`MS_NS / `CLK_NS)
`define LINE_COUNT          13
`endif

// File: iosd_pkg.sv
// Purpose: types for the sampling and diagnostics block
// Assumes: nothing
// Notes: types only, constants live in the cfg header
package iosd_pkg;
	typedef enum logic [1:0] {
		CMD_IDLE   = 2'b00,
		CMD_WRITE  = 2'b01,
		CMD_READ   = 2'b10,
		CMD_COMMIT = 2'b11
	} cmd_t;
	typedef enum logic [1:0] {
		TICK_OFF = 2'b01,
		TICK_RUN = 2'b10
	} tick_state_t;
endpackage

// File: ms_ticker.sv
// Purpose: divides the clock into millisecond ticks and counts a period
// Assumes: period already validated by the caller
// Notes: period of zero expires every millisecond; only run low holds the timer stopped
`timescale 1ns/1ps
`include "iosd_cfg.svh"
module ms_ticker
	import iosd_pkg::*;
#(
	parameter int CYC_MS = `CYC_PER_MS
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [15:0] period_ms,
	input  wire logic        run,
	output logic             expire
);
	initial begin
		if (CYC_MS < 1) $error("CYC_MS must be at least one");
	end

	tick_state_t st_q, st_d;
	logic [31:0] cyc_q, cyc_d;
	logic [15:0] ms_q, ms_d;
	logic        exp_q, exp_d;

	// next state; nothing else restarts this timer, so change samples never disturb it
	always_comb begin
		st_d  = st_q;
		cyc_d = cyc_q;
		ms_d  = ms_q;
		exp_d = 1'b0;
		unique case (st_q)
			TICK_OFF: begin
				cyc_d = 32'h0;
				ms_d  = 16'h0;
				if (run) st_d = TICK_RUN;
			end
			TICK_RUN: begin
				if (!run) begin
					st_d = TICK_OFF;
				end else if (cyc_q == 32'(CYC_MS - 1)) begin
					cyc_d = 32'h0;
					if (ms_q + 16'h1 >= period_ms) begin
						ms_d  = 16'h0;
						exp_d = 1'b1;
					end else begin
						ms_d = ms_q + 16'h1;
					end
				end else begin
					cyc_d = cyc_q + 32'h1;
				end
			end
			default: st_d = TICK_OFF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q  <= TICK_OFF;
			cyc_q <= 32'h0;
			ms_q  <= 16'h0;
			exp_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cyc_q <= cyc_d;
			ms_q  <= ms_d;
			exp_q <= exp_d;
		end
	end

	assign expire = exp_q;
endmodule // ms_ticker

// File: line_watch.sv
// Purpose: synchronises digital lines and flags masked changes
// Assumes: lines are asynchronous pins
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module line_watch #(
	parameter int N = 13
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] lines,
	input  wire logic [N-1:0] watch,
	output logic [N-1:0]      level,
	output logic              changed
);
	initial begin
		if (N < 1 || N > 16) $error("N out of range");
	end

	logic [N-1:0] s1_q, s2_q, prev_q, hit;

	// per-line edge detect after the two-flop synchroniser
	for (genvar i = 0; i < N; i++) begin : g_line
		always_ff @(posedge clk) begin
			if (!rstn) begin
				s1_q[i]   <= 1'b0;
				s2_q[i]   <= 1'b0;
				prev_q[i] <= 1'b0;
			end else begin
				s1_q[i]   <= lines[i];
				s2_q[i]   <= s1_q[i];
				prev_q[i] <= s2_q[i];
			end
		end
		assign hit[i] = watch[i] & (s2_q[i] ^ prev_q[i]);
	end

	assign level   = s2_q;
	assign changed = |hit;
endmodule // line_watch

// File: io_sampling_diagnostics.sv
// Purpose: settings, status and sample triggering for I/O sampling
// Assumes: host command decoder drives the param port on clk
// Notes: writes queue until commit, except the strength clear; status values come in from the radio side
// Contract
// - nonzero period samples enabled inputs once per period in milliseconds
// - period is zero (off, reset) or 0x32..0xFFFF; others refused
// - periodic sampling needs nonzero period and at least one enabled pin
// - every sample set goes to the destination high/low address
// - masked digital line change sends a sample set at once
// - mask bit n watches line n for 0..12; mask resets to zero
// - supply at or below threshold appends reading, sets channel bit 7
// - threshold zero, the reset value, disables supply inclusion
// - firmware version is read-only, sixteen bits, four hex digits
// - hardware version read-only: high byte type, low byte revision
// - join status reads 0x00 when joined, 0xFF during start-up
// - supply voltage status is read-only millivolts, sixteen bits
// - signal strength holds magnitude in negative dBm
// - writing zero clears strength; next packet updates it, last hop
// - temperature on high-power variant is signed whole degrees
// - execution actions act at once, no commit needed
// - commit applies all queued values together, stays in command mode
`timescale 1ns/1ps
`include "iosd_cfg.svh"
module io_sampling_diagnostics
	import iosd_pkg::*;
#(
	parameter int          LINES      = `LINE_COUNT,
	parameter int          CYC_MS     = `CYC_PER_MS,
	parameter logic [15:0] FW_VERSION = 16'h1234, // arbitrary value
	parameter logic [15:0] HW_VERSION = 16'h5A01, // arbitrary value
	parameter bit          HIGH_POWER = 1'b1
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [1:0]       cmd,
	input  wire logic [3:0]       cmd_index,
	input  wire logic [15:0]      cmd_wdata,
	output logic [15:0]           cmd_rdata,
	output logic                  cmd_done,
	output logic                  cmd_error,
	input  wire logic [LINES-1:0] dio_lines,
	input  wire logic [LINES-1:0] dio_enabled,
	input  wire logic             analog_enabled,
	input  wire logic [7:0]       join_code,
	input  wire logic [15:0]      supply_mv_in,
	input  wire logic [7:0]       rx_strength,
	input  wire logic             rx_valid,
	input  wire logic [15:0]      temp_in,
	output logic                  sample_req,
	output logic                  sample_from_change,
	output logic [31:0]           sample_dest,
	output logic [LINES-1:0]      sample_levels,
	output logic                  sample_supply_en,
	output logic [15:0]           sample_supply_mv,
	output logic [7:0]            analog_mask_hi,
	output logic [15:0]           serial_rate
);
	initial begin
		if (LINES != `LINE_COUNT) $error("LINES must match change mask width");
	end

	cmd_t cmd_c;
	assign cmd_c = cmd_t'(cmd);

	// queued (pending) and active settings
	logic [15:0] per_pend_q, per_pend_d, per_q, per_d;
	logic [15:0] msk_pend_q, msk_pend_d, msk_q, msk_d;
	logic [15:0] thr_pend_q, thr_pend_d, thr_q, thr_d;
	logic [15:0] dh_pend_q, dh_pend_d, dh_q, dh_d;
	logic [15:0] dl_pend_q, dl_pend_d, dl_q, dl_d;
	logic [15:0] br_pend_q, br_pend_d, br_q, br_d;
	logic [7:0]  hop_q, hop_d;
	logic [15:0] rd_q, rd_d;
	logic        done_q, done_d, err_q, err_d;

	// status inputs come from elsewhere in the device: sample them twice
	logic [7:0]  join_s1_q, join_s2_q;
	logic [15:0] vcc_s1_q, vcc_s2_q, tmp_s1_q, tmp_s2_q;
	logic [7:0]  rxs_s1_q, rxs_s2_q;
	logic        rxv_s1_q, rxv_s2_q, rxv_p_q;
	logic        rx_event;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			join_s1_q <= `JOIN_INIT;
			join_s2_q <= `JOIN_INIT;
			vcc_s1_q  <= 16'h0;
			vcc_s2_q  <= 16'h0;
			tmp_s1_q  <= 16'h0;
			tmp_s2_q  <= 16'h0;
			rxs_s1_q  <= 8'h0;
			rxs_s2_q  <= 8'h0;
			rxv_s1_q  <= 1'b0;
			rxv_s2_q  <= 1'b0;
			rxv_p_q   <= 1'b0;
		end else begin
			join_s1_q <= join_code;
			join_s2_q <= join_s1_q;
			vcc_s1_q  <= supply_mv_in;
			vcc_s2_q  <= vcc_s1_q;
			tmp_s1_q  <= temp_in;
			tmp_s2_q  <= tmp_s1_q;
			rxs_s1_q  <= rx_strength;
			rxs_s2_q  <= rxs_s1_q;
			rxv_s1_q  <= rx_valid;
			rxv_s2_q  <= rxv_s1_q;
			rxv_p_q   <= rxv_s2_q;
		end
	end
	// packet arrival is a rising edge of the synchronised valid
	assign rx_event = rxv_s2_q & ~rxv_p_q;

	// command port: queue settings writes, clear strength at once, answer reads, commit on request
	always_comb begin
		per_pend_d = per_pend_q;
		msk_pend_d = msk_pend_q;
		thr_pend_d = thr_pend_q;
		dh_pend_d  = dh_pend_q;
		dl_pend_d  = dl_pend_q;
		br_pend_d  = br_pend_q;
		per_d      = per_q;
		msk_d      = msk_q;
		thr_d      = thr_q;
		dh_d       = dh_q;
		dl_d       = dl_q;
		br_d       = br_q;
		hop_d      = hop_q;
		rd_d       = rd_q;
		done_d     = 1'b0;
		err_d      = 1'b0;
		if (rx_event) hop_d = rxs_s2_q;
		unique case (cmd_c)
			CMD_IDLE: ;
			CMD_WRITE: begin
				done_d = 1'b1;
				unique case (cmd_index)
					`PAR_SAMPLE_PERIOD: begin
						if (cmd_wdata == 16'h0 || cmd_wdata >= `PERIOD_MIN)
							per_pend_d = cmd_wdata;
						else
							err_d = 1'b1;
					end
					`PAR_CHANGE_MASK:   msk_pend_d = cmd_wdata;
					`PAR_SUPPLY_THRESH: thr_pend_d = cmd_wdata;
					`PAR_DEST_HIGH:     dh_pend_d  = cmd_wdata;
					`PAR_DEST_LOW:      dl_pend_d  = cmd_wdata;
					`PAR_SERIAL_RATE:   br_pend_d  = cmd_wdata;
					// clear acts at once; a packet in the same cycle wins
					`PAR_LAST_HOP: begin
						if (cmd_wdata == 16'h0 && !rx_event)
							hop_d = 8'h0;
						else if (cmd_wdata != 16'h0)
							err_d = 1'b1;
					end
					default: err_d = 1'b1; // read-only or unmapped
				endcase
			end
			CMD_READ: begin
				done_d = 1'b1;
				unique case (cmd_index)
					`PAR_SAMPLE_PERIOD: rd_d = per_pend_q;
					`PAR_CHANGE_MASK:   rd_d = msk_pend_q;
					`PAR_SUPPLY_THRESH: rd_d = thr_pend_q;
					`PAR_DEST_HIGH:     rd_d = dh_pend_q;
					`PAR_DEST_LOW:      rd_d = dl_pend_q;
					`PAR_SERIAL_RATE:   rd_d = br_pend_q;
					`PAR_FW_VERSION:    rd_d = FW_VERSION;
					`PAR_HW_VERSION:    rd_d = HW_VERSION;
					`PAR_JOIN_STATUS:   rd_d = {8'h0, join_s2_q};
					`PAR_SUPPLY_MV:     rd_d = vcc_s2_q;
					`PAR_LAST_HOP:      rd_d = {8'h0, hop_q};
					`PAR_TEMPERATURE: begin
						if (HIGH_POWER) rd_d = tmp_s2_q;
						else err_d = 1'b1;
					end
					default: begin
						rd_d  = 16'h0;
						err_d = 1'b1;
					end
				endcase
			end
			// commit acts at once, all settings together
			CMD_COMMIT: begin
				done_d = 1'b1;
				per_d  = per_pend_q;
				msk_d  = msk_pend_q;
				thr_d  = thr_pend_q;
				dh_d   = dh_pend_q;
				dl_d   = dl_pend_q;
				br_d   = br_pend_q;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			per_pend_q <= 16'h0;
			msk_pend_q <= 16'h0;
			thr_pend_q <= 16'h0;
			dh_pend_q  <= 16'h0;
			dl_pend_q  <= 16'h0;
			br_pend_q  <= 16'h0;
			per_q      <= 16'h0;
			msk_q      <= 16'h0;
			thr_q      <= 16'h0;
			dh_q       <= 16'h0;
			dl_q       <= 16'h0;
			br_q       <= 16'h0;
			hop_q      <= 8'h0;
			rd_q       <= 16'h0;
			done_q     <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			per_pend_q <= per_pend_d;
			msk_pend_q <= msk_pend_d;
			thr_pend_q <= thr_pend_d;
			dh_pend_q  <= dh_pend_d;
			dl_pend_q  <= dl_pend_d;
			br_pend_q  <= br_pend_d;
			per_q      <= per_d;
			msk_q      <= msk_d;
			thr_q      <= thr_d;
			dh_q       <= dh_d;
			dl_q       <= dl_d;
			br_q       <= br_d;
			hop_q      <= hop_d;
			rd_q       <= rd_d;
			done_q     <= done_d;
			err_q      <= err_d;
		end
	end

	logic run, tick, chg;
	logic [LINES-1:0] lvl;
	assign run = (per_q != 16'h0) && ((|dio_enabled) || analog_enabled);

	ms_ticker #(.CYC_MS(CYC_MS)) u_tick (
		.clk       (clk),
		.rstn      (rstn),
		.period_ms (per_q),
		.run       (run),
		.expire    (tick)
	);

	line_watch #(.N(LINES)) u_watch (
		.clk     (clk),
		.rstn    (rstn),
		.lines   (dio_lines),
		.watch   (msk_q[LINES-1:0] & dio_enabled),
		.level   (lvl),
		.changed (chg)
	);

	// sample output stage; data registered, one-cycle request
	logic             req_q, req_d, fch_q, fch_d, sup_q, sup_d;
	logic [31:0]      dst_q, dst_d;
	logic [LINES-1:0] lv_q, lv_d;
	logic [15:0]      smv_q, smv_d;

	always_comb begin
		req_d = tick | chg;
		fch_d = chg;
		dst_d = dst_q;
		lv_d  = lv_q;
		sup_d = sup_q;
		smv_d = smv_q;
		if (tick | chg) begin
			dst_d = {dh_q, dl_q};
			lv_d  = lvl;
			sup_d = (thr_q != 16'h0) && (vcc_s2_q <= thr_q);
			smv_d = vcc_s2_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			req_q <= 1'b0;
			fch_q <= 1'b0;
			dst_q <= 32'h0;
			lv_q  <= '0;
			sup_q <= 1'b0;
			smv_q <= 16'h0;
		end else begin
			req_q <= req_d;
			fch_q <= fch_d;
			dst_q <= dst_d;
			lv_q  <= lv_d;
			sup_q <= sup_d;
			smv_q <= smv_d;
		end
	end

	assign sample_req         = req_q;
	assign sample_from_change = fch_q;
	assign sample_dest        = dst_q;
	assign sample_levels      = lv_q;
	assign sample_supply_en   = sup_q;
	assign sample_supply_mv   = smv_q;
	assign analog_mask_hi     = {sup_q, 7'h0};
	// serial rate only moves on commit
	assign serial_rate        = br_q;
	assign cmd_rdata          = rd_q;
	assign cmd_done           = done_q;
	assign cmd_error          = err_q;

	period_legal_a: assert property (@(posedge clk) disable iff (!rstn)
		(per_pend_q == 16'h0 || per_pend_q >= `PERIOD_MIN))
		else $error("queued period illegal");
	commit_copy_a: assert property (@(posedge clk) disable iff (!rstn)
		cmd_c == CMD_COMMIT |=> per_q == $past(per_pend_q) && br_q == $past(br_pend_q))
		else $error("commit did not copy");
	// no periodic samples when gated off
	gate_off_a: assert property (@(posedge clk) disable iff (!rstn)
		!run [*3] |-> !tick)
		else $error("periodic tick while off");
	thr_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		(req_d && thr_q == 16'h0) |=> !sample_supply_en)
		else $error("supply included with zero threshold");
	// supply at or below threshold sets bit 7
	mask_bit_a: assert property (@(posedge clk) disable iff (!rstn)
		((tick || chg) && thr_q != 16'h0 && vcc_s2_q <= thr_q)
		|=> analog_mask_hi[`SUPPLY_MASK_BIT])
		else $error("channel mask bit 7 not set");
	change_req_a: assert property (@(posedge clk) disable iff (!rstn)
		chg |=> sample_req && sample_from_change)
		else $error("change not sampled");
	dest_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		req_d |=> sample_dest == {$past(dh_q), $past(dl_q)})
		else $error("wrong destination");
	hop_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		(cmd_c == CMD_WRITE && cmd_index == `PAR_LAST_HOP && cmd_wdata == 16'h0
		 && !rx_event) |=> hop_q == 8'h0)
		else $error("strength not cleared");
	fw_read_a: assert property (@(posedge clk) disable iff (!rstn)
		(cmd_c == CMD_READ && cmd_index == `PAR_FW_VERSION) |=> cmd_rdata == FW_VERSION)
		else $error("firmware version wrong");

	periodic_c: cover property (@(posedge clk) disable iff (!rstn) tick);
	change_c:   cover property (@(posedge clk) disable iff (!rstn) chg);
	supply_c:   cover property (@(posedge clk) disable iff (!rstn) sample_supply_en);
	commit_c:   cover property (@(posedge clk) disable iff (!rstn) cmd_c == CMD_COMMIT);
endmodule // io_sampling_diagnostics

// File: host_model.sv
// Purpose: host side model driving the parameter command port
// Assumes: one command per call, driven on the rising edge
// Notes: leaves one idle cycle after each command
`timescale 1ns/1ps
module host_model (
	input  wire logic  clk,
	output logic [1:0] cmd,
	output logic [3:0] cmd_index,
	output logic [15:0] cmd_wdata
);
	// idle port from time zero
	initial begin
		cmd = 2'h0;
		cmd_index = 4'h0;
		cmd_wdata = 16'h0000;
	end

	// one command cycle, held until the taking edge
	task issue(input logic [1:0] c, input logic [3:0] i, input logic [15:0] d);
		// never a 1 or 2 ms period
		if (i == 4'h0 && (d == 16'h0001 || d == 16'h0002))
			d = 16'h0032;
		if (i == 4'h1)
			d = d & 16'h1FFF;
		@(posedge clk);
		cmd <= c;
		cmd_index <= i;
		cmd_wdata <= d;
		@(posedge clk);
		cmd <= 2'h0;
	endtask
endmodule // host_model

// File: tb_io_sampling_diagnostics.sv
// Purpose: self-checking bench for the sampling and diagnostics block
// Assumes: millisecond shortened to 4 cycles
// Notes: command answers checked from a queue at the falling edge
`timescale 1ns/1ps
module tb_io_sampling_diagnostics;
	localparam logic [15:0] FW = 16'h0C3A; // arbitrary value
	localparam logic [15:0] HW = 16'h7702; // arbitrary value
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [1:0]  cmd;
	logic [3:0]  cmd_index;
	logic [15:0] cmd_wdata, cmd_rdata, supply_mv_in, temp_in, serial_rate, sample_supply_mv;
	logic        cmd_done, cmd_error, analog_enabled, rx_valid, sample_req;
	logic        sample_from_change, sample_supply_en;
	logic [12:0] dio_lines, dio_enabled, sample_levels;
	logic [7:0]  join_code, rx_strength, analog_mask_hi;
	logic [31:0] sample_dest, dst;
	logic [17:0] exq[$];
	logic [17:0] e;
	logic [7:0]  jc[12] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27,
		8'h2A, 8'h2B, 8'h2C, 8'hAB, 8'hAD, 8'hAF};
	logic [15:0] j, p;
	int fails = 0, checks_done = 0, cyc = 0, ntick = 0, nchg = 0, last_t = 0, prev_t = 0, n;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	host_model u_host_model (.clk(clk), .cmd(cmd), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata));

	io_sampling_diagnostics #(.CYC_MS(4), .FW_VERSION(FW), .HW_VERSION(HW))
	u_io_sampling_diagnostics (.clk(clk), .rstn(rstn), .cmd(cmd), .cmd_index(cmd_index),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_done(cmd_done),
		.cmd_error(cmd_error), .dio_lines(dio_lines), .dio_enabled(dio_enabled),
		.analog_enabled(analog_enabled), .join_code(join_code), .supply_mv_in(supply_mv_in),
		.rx_strength(rx_strength), .rx_valid(rx_valid), .temp_in(temp_in),
		.sample_req(sample_req), .sample_from_change(sample_from_change),
		.sample_dest(sample_dest), .sample_levels(sample_levels),
		.sample_supply_en(sample_supply_en), .sample_supply_mv(sample_supply_mv),
		.analog_mask_hi(analog_mask_hi), .serial_rate(serial_rate));

	task check(input string nm, input logic [31:0] ex, input logic [31:0] seen);
		checks_done++;
		if (seen !== ex) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, ex, seen);
		end
	endtask

	task results;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// note the answer, then send the command
	task op(input logic [1:0] c, input logic [3:0] i, input logic [15:0] d,
		input logic er, input logic ck, input logic [15:0] ex);
		exq.push_back({ck, er, ex});
		u_host_model.issue(c, i, d);
	endtask
	task wr(input logic [3:0] i, input logic [15:0] d, input logic er);
		op(2'h1, i, d, er, 1'b0, 16'h0000);
	endtask
	task rd(input logic [3:0] i, input logic [15:0] ex);
		op(2'h2, i, 16'h0000, 1'b0, 1'b1, ex);
	endtask
	task commit;
		op(2'h3, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h0000);
	endtask
	// one received packet, held long enough to cross the synchroniser
	task pkt(input logic [7:0] s);
		rx_strength <= s;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task wait_ticks(input int k);
		int t0, w;
		t0 = ntick;
		w = 0;
		while (ntick < t0 + k && w < 1000) begin
			@(negedge clk);
			w++;
		end
		check("tick wait", 1, w < 1000);
	endtask

	// hang guard, read on the rising edge so it never races the counter
	always @(posedge clk) begin
		if (cyc >= 30000) begin
			fails++;
			results;
		end
	end

	// answer and sample watcher
	always @(negedge clk) begin
		cyc++;
		if (rstn && cmd_done === 1'b1) begin
			e = exq.size() ? exq.pop_front() : 18'h3FFFF;
			check("error", e[16], cmd_error);
			if (e[17])
				check("rdata", e[15:0], cmd_rdata);
		end
		if (rstn && sample_req === 1'b1) begin
			if (sample_from_change === 1'b1)
				nchg++;
			else begin
				prev_t = last_t;
				last_t = cyc;
				ntick++;
			end
		end
	end

	initial begin
		dio_lines = 13'h0;
		dio_enabled = 13'h0;
		analog_enabled = 1'b0;
		join_code = 8'hFF;
		supply_mv_in = 16'h0CE4;
		rx_strength = 8'h00;
		rx_valid = 1'b0;
		temp_in = 16'hFFFF;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		dst = $urandom(32'hA15C);
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		rd(4'h2, 16'h0000);
		rd(4'h8, 16'h00FF);
		rd(4'h6, FW);
		rd(4'h7, HW);
		rd(4'h9, 16'h0CE4);
		rd(4'hB, 16'hFFFF);
		// read-only, unmapped and nonzero strength writes all refused
		for (int i = 6; i < 16; i++)
			wr(4'(i), 16'h0001, 1'b1);
		foreach (jc[k]) begin
			join_code <= jc[k];
			repeat (4) @(posedge clk);
			rd(4'h8, {8'h00, jc[k]});
		end
		join_code <= 8'h00;
		n = 0;
		do begin
			op(2'h2, 4'h8, 16'h0000, 1'b0, 1'b0, 16'h0000);
			@(negedge clk);
			j = cmd_rdata;
			n++;
		end while (j !== 16'h0000 && n < 20);
		check("join", 16'h0000, j);
		@(posedge clk);
		pkt(8'h50);
		rd(4'hA, 16'h0050);
		wr(4'hA, 16'h0000, 1'b0);
		rd(4'hA, 16'h0000);
		// a later packet refills the cleared strength
		pkt(8'h3C);
		rd(4'hA, 16'h003C);
		wr(4'h0, 16'h0031, 1'b1);
		p = 16'h0032 + 16'($urandom % 16'hFFCE);
		wr(4'h0, p, 1'b0);
		rd(4'h0, p);
		wr(4'h0, 16'h0032, 1'b0);
		wr(4'h5, 16'h0009, 1'b0);
		wr(4'h3, dst[31:16], 1'b0);
		wr(4'h4, dst[15:0], 1'b0);
		dio_enabled <= 13'h1001;
		repeat (250) @(posedge clk);
		@(negedge clk);
		check("queued", 0, ntick);
		check("rate", 16'h0000, serial_rate);
		commit;
		@(negedge clk);
		check("rate", 16'h0009, serial_rate);
		wait_ticks(2);
		check("period", 200, last_t - prev_t);
		check("dest", dst, sample_dest);
		check("supply off", 0, sample_supply_en);
		wr(4'h1, 16'h1008, 1'b0);
		commit;
		wait_ticks(1);
		repeat (20) @(posedge clk);
		dio_lines <= 13'h0009;
		repeat (10) @(posedge clk);
		check("unmasked", 0, nchg);
		dio_lines <= 13'h1009;
		repeat (10) @(posedge clk);
		@(negedge clk);
		check("change", 1, nchg);
		check("level", 1, sample_levels[12]);
		wait_ticks(1);
		check("timer kept", 200, last_t - prev_t);
		// no pin enabled, no periodic samples
		@(posedge clk);
		dio_enabled <= 13'h0;
		repeat (2) @(posedge clk);
		n = ntick;
		repeat (450) @(posedge clk);
		check("no pins", n, ntick);
		analog_enabled <= 1'b1;
		wr(4'h2, 16'h0CE4, 1'b0);
		commit;
		wait_ticks(2);
		check("supply en", 1, sample_supply_en);
		check("mask", 8'h80, analog_mask_hi);
		check("supply mv", 16'h0CE4, sample_supply_mv);
		wr(4'h2, 16'h0CE3, 1'b0);
		commit;
		wait_ticks(2);
		check("supply above", 0, sample_supply_en);
		// mid-run reset: settings and outputs back to reset values
		repeat (4) @(posedge clk);
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(4'h8, 16'h00FF);
		rd(4'h1, 16'h0000);
		@(negedge clk);
		check("rate reset", 16'h0000, serial_rate);
		check("supply reset", 0, sample_supply_en);
		check("mask reset", 8'h00, analog_mask_hi);
		repeat (4) @(posedge clk);
		results;
	end
endmodule // tb_io_sampling_diagnostics
